//--- hdl/eeprom_byte_prog_erase_ctrl.sv
// Function
// - 256 nonvolatile bytes at array indices 0x100 to 0x1ff, each byte erasable alone.
// - 255 general bytes; byte at index 0x100 holds the option settings.
// - No bulk or row erase; only single byte erase exists.
// - Control registers within first 32 indices; CAN area the next 30.
// - Control register at index 0x007 resets to zero; bits 5 and 4 read zero.
// - Bit 7 wired-OR irq enable, forced zero without mask option, cleared at reset.
// - Bit 6 set when CAN sleeps, cleared when it wakes.
// - With latch and pump set, erase select picks erase (1) or program (0).
// - After address latched, erase select cannot change.
// - Latch set, pump clear: array write captures address and data.
// - Latch clear forces erase select and pump clear; array reads normally.
// - STOP entry and resets clear the latch enable bit.
// - Pump enable switches the high voltage generator on and off.
// - Pump refuses to set before data latched; clears only via latch clear.
// - Bits erase/latch/pump decode: 000 read, 010, 011, 110, 111.
// - Array read with latch set returns 0xff; while the pump is on the code refuses it with an error instead.
// - During an erase no array access completes successfully.
// - Erased byte reads 0xff, programmed bits read 0; erase data ignored.
// - After latching, writes to other array addresses do nothing.
// - Option protect bit zero rejects program and erase to indices 0x120-0x1ff.
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps

module eeprom_byte_prog_erase_ctrl
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        woi_mask_option,
    input  wire logic        can_sleep_enter,
    input  wire logic        can_wake,
    input  wire logic        stop_entry,
    output logic             wired_or_irq_enable,
    output logic             can_asleep_flag,
    output logic             bus_clock_out_option,
    output logic             pump_voltage_pin,
    output logic             array_latched
);

    // Nonvolatile cells come up unknown; software erases a byte before programming it.
    logic [7:0]                         mem [eeprom_ctrl_pkg::ARR_DEPTH];
    logic                               irq_en_reg;
    logic                               asleep_reg;
    logic                               clkopt_reg;
    logic                               erase_reg;
    logic                               latch_reg;
    logic                               pump_reg;
    logic                               addr_valid_reg;
    logic [eeprom_ctrl_pkg::ARR_AW-1:0] addr_reg;
    logic [7:0]                         data_reg;
    logic                               protect_open_reg;
    logic                               opt_loaded_reg;
    logic [31:0]                        prdata_reg;
    logic                               pslverr_reg;

    logic                               access;
    logic [eeprom_ctrl_pkg::IDX_W-1:0]  idx;
    logic                               ctrl_hit;
    logic                               status_hit;
    logic                               array_hit;
    logic [eeprom_ctrl_pkg::ARR_AW-1:0] arr_addr;
    logic                               ctrl_wr;
    logic                               array_busy;
    logic                               arr_wr;
    logic                               latch_next;
    logic                               op_done;
    logic [7:0]                         ctrl_view;
    logic [7:0]                         status_view;
    eeprom_ctrl_pkg::array_mode_e       mode;
    // Bus phase, latch qualification and read answer terms.
    logic                               setup;
    logic                               addr_match;
    logic                               target_ok;
    logic                               capture;
    logic [31:0]                        prdata_next;
    logic                               pslverr_next;

    // Both bounds are inclusive.
    function automatic logic in_range(
        input logic [eeprom_ctrl_pkg::IDX_W-1:0] a,
        input logic [eeprom_ctrl_pkg::IDX_W-1:0] lo,
        input logic [eeprom_ctrl_pkg::IDX_W-1:0] hi
    );
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    // Upper region is closed to program and erase unless the option opens it.
    function automatic logic target_allowed(
        input logic [eeprom_ctrl_pkg::ARR_AW-1:0] a,
        input logic                               open_upper
    );
        logic [eeprom_ctrl_pkg::IDX_W-1:0] full;
        full = eeprom_ctrl_pkg::ARR_FIRST | {2'b00, a};
        target_allowed = open_upper || (full < eeprom_ctrl_pkg::UPPER_LO);
    endfunction : target_allowed

    // Every readable item is one byte wide and sits in the low lane of the word.
    function automatic logic [31:0] low_byte(
        input logic [7:0] b
    );
        low_byte = {24'h000000, b};
    endfunction : low_byte

    assign access     = psel && penable;
    assign setup      = psel && !penable;
    // The two low address bits are ignored; every index is one aligned word.
    assign idx        = paddr[eeprom_ctrl_pkg::ADDR_W-1:eeprom_ctrl_pkg::IDX_LSB];
    assign ctrl_hit   = (idx == eeprom_ctrl_pkg::CTRL_IDX);
    assign status_hit = (idx == eeprom_ctrl_pkg::STATUS_IDX);
    assign array_hit  = in_range(idx, eeprom_ctrl_pkg::ARR_FIRST, eeprom_ctrl_pkg::ARR_LAST);
    assign arr_addr   = idx[eeprom_ctrl_pkg::ARR_AW-1:0];
    assign ctrl_wr    = access && pwrite && ctrl_hit && pstrb[0];
    // Programming counts as busy too: a cell under high voltage is neither read nor written.
    // busy during operation
    assign array_busy = pump_reg;
    assign arr_wr     = access && pwrite && array_hit && !array_busy && pstrb[0];

    // STOP wins over a control write in the same cycle, so low-power entry
    // always leaves the array in the read state.
    // stop clears latch
    always_comb
    begin
        if (stop_entry)
            latch_next = 1'b0;
        else if (ctrl_wr)
            latch_next = pwdata[eeprom_ctrl_pkg::LATCH_BIT];
        else
            latch_next = latch_reg;
    end

    // The cell only changes when the pumped phase ends by a software latch clear.
    // A STOP entry aborts the operation and leaves the cell untouched.
    assign op_done = pump_reg && ctrl_wr && !pwdata[eeprom_ctrl_pkg::LATCH_BIT] && !stop_entry;

    // Codes 001, 100 and 101 cannot be held, because erase select and pump clear
    // with the latch; the default sends them to the read state.
    // mode decode
    always_comb
    begin
        unique case ({erase_reg, latch_reg, pump_reg})
            3'b010:  mode = eeprom_ctrl_pkg::ST_LOAD_PROG;
            3'b011:  mode = eeprom_ctrl_pkg::ST_PROGRAMMING;
            3'b110:  mode = eeprom_ctrl_pkg::ST_LOAD_ERASE;
            3'b111:  mode = eeprom_ctrl_pkg::ST_ERASING;
            default: mode = eeprom_ctrl_pkg::ST_READ;
        endcase
    end

    // The mask option overrides software on every cycle, so the enable can never
    // stand set on a part built without wired-OR interrupts.
    // wired-OR enable gated by mask option
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq_en_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::IRQ_EN_BIT];
        else if (!woi_mask_option)
            irq_en_reg <= 1'b0;
        else if (ctrl_wr)
            irq_en_reg <= pwdata[eeprom_ctrl_pkg::IRQ_EN_BIT];
    end

    // A sleep entry and a wake in the same cycle leave the flag set, so a sleep
    // is never missed by software polling the control register.
    // CAN sleep flag
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            asleep_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::ASLEEP_BIT];
        else if (can_sleep_enter)
            asleep_reg <= 1'b1;
        else if (can_wake)
            asleep_reg <= 1'b0;
    end

    // The clock output option is only stored here; the pin logic sits elsewhere.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clkopt_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::CLKOPT_BIT];
        else if (ctrl_wr)
            clkopt_reg <= pwdata[eeprom_ctrl_pkg::CLKOPT_BIT];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            latch_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::LATCH_BIT];
        else
            latch_reg <= latch_next;
    end

    // Erase select may still change in the same write that sets the latch.
    // erase select frozen once latched
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            erase_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::ERASE_BIT];
        else if (!latch_next)
            erase_reg <= 1'b0;
        else if (ctrl_wr && !addr_valid_reg)
            erase_reg <= pwdata[eeprom_ctrl_pkg::ERASE_BIT];
    end

    // Software cannot switch the pump off on its own: only the latch clear ends
    // an operation, and that same clear commits the cell.
    // pump needs latched data, holds until latch clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pump_reg <= eeprom_ctrl_pkg::CTRL_RESET[eeprom_ctrl_pkg::PUMP_BIT];
        else if (!latch_next)
            pump_reg <= 1'b0;
        else if (ctrl_wr && !pump_reg)
            pump_reg <= pwdata[eeprom_ctrl_pkg::PUMP_BIT] && addr_valid_reg;
    end

    assign addr_match = !addr_valid_reg || (arr_addr == addr_reg);
    assign target_ok  = target_allowed(arr_addr, protect_open_reg);
    assign capture    = latch_next && latch_reg && arr_wr && addr_match && target_ok;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            addr_valid_reg <= 1'b0;
        else if (!latch_next)
            addr_valid_reg <= 1'b0;
        else if (capture)
            addr_valid_reg <= 1'b1;
    end

    // A rewrite of the latched address reloads the data, so software may still
    // correct the byte before it switches the pump on. The latch keeps its last
    // contents after a clear; only the valid flag says whether they count.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_reg <= '0;
            data_reg <= '0;
        end
        else if (capture)
        begin
            addr_reg <= arr_addr;
            data_reg <= pwdata[7:0];
        end
    end

    // The option is sampled once after reset release, like a strap, so a later
    // change to the option byte only acts after the next reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            opt_loaded_reg   <= 1'b0;
            protect_open_reg <= 1'b0;
        end
        else if (!opt_loaded_reg)
        begin
            opt_loaded_reg   <= 1'b1;
            protect_open_reg <= mem[eeprom_ctrl_pkg::OPTION_ADDR][eeprom_ctrl_pkg::OPT_PROTECT_BIT];
        end
    end

    // Nonvolatile cells are not touched by reset.
    always_ff @(posedge pclk)
    begin
        if (op_done)
        begin
            if (erase_reg)
                mem[addr_reg] <= eeprom_ctrl_pkg::ERASED_BYTE;
            else
                mem[addr_reg] <= mem[addr_reg] & data_reg;
        end
    end

    // Bits 5 and 4 have no storage and always read zero.
    always_comb
    begin
        ctrl_view = 8'h00;
        ctrl_view[eeprom_ctrl_pkg::IRQ_EN_BIT] = irq_en_reg;
        ctrl_view[eeprom_ctrl_pkg::ASLEEP_BIT] = asleep_reg;
        ctrl_view[eeprom_ctrl_pkg::CLKOPT_BIT] = clkopt_reg;
        ctrl_view[eeprom_ctrl_pkg::ERASE_BIT]  = erase_reg;
        ctrl_view[eeprom_ctrl_pkg::LATCH_BIT]  = latch_reg;
        ctrl_view[eeprom_ctrl_pkg::PUMP_BIT]   = pump_reg;
    end

    // Status is a read-only view; writes to its index are ignored.
    always_comb
    begin
        status_view = 8'h00;
        status_view[eeprom_ctrl_pkg::ST_LATCHED_BIT] = addr_valid_reg;
        status_view[eeprom_ctrl_pkg::ST_PROTECT_BIT] = protect_open_reg;
        status_view[eeprom_ctrl_pkg::ST_PUMP_BIT]    = pump_reg;
        status_view[eeprom_ctrl_pkg::ST_ERASE_BIT]   = (mode == eeprom_ctrl_pkg::ST_ERASING);
    end

    // The answer is chosen from the state seen at the setup edge, so a write in
    // the access phase of the same transfer cannot change what is read back.
    always_comb
    begin
        prdata_next  = eeprom_ctrl_pkg::ZERO_WORD;
        pslverr_next = 1'b0;
        if (ctrl_hit)
            prdata_next = low_byte(ctrl_view);
        else if (status_hit)
            prdata_next = low_byte(status_view);
        else if (array_hit && array_busy)
            pslverr_next = 1'b1;
        else if (array_hit && latch_reg)
            prdata_next = low_byte(eeprom_ctrl_pkg::LATCHED_READ);
        else if (array_hit)
            prdata_next = low_byte(mem[arr_addr]);
        // other register and CAN slots belong elsewhere
        else
            pslverr_next = 1'b1;
    end

    // Read data is registered at the setup edge and stands through the access
    // phase; the slave answers with zero wait states.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= eeprom_ctrl_pkg::ZERO_WORD;
        else if (setup)
            prdata_reg <= prdata_next;
    end

    // The error is captured at the same edge as the data it belongs to.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pslverr_reg <= 1'b0;
        else if (setup)
            pslverr_reg <= pslverr_next;
    end

    // Every access finishes in its first access cycle, so ready is tied high.
    assign pready               = 1'b1;
    assign prdata               = prdata_reg;
    // An error is only shown to the master while the access phase lasts.
    assign pslverr              = pslverr_reg && access;
    assign wired_or_irq_enable  = irq_en_reg;
    assign can_asleep_flag      = asleep_reg;
    assign bus_clock_out_option = clkopt_reg;
    assign pump_voltage_pin     = pump_reg;
    // The latch pin tells the core that the array buses are held and fetch must go elsewhere.
    assign array_latched        = latch_reg;

endmodule : eeprom_byte_prog_erase_ctrl

//--- hdl/eeprom_ctrl_pkg.sv
package eeprom_ctrl_pkg;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam int unsigned ADDR_W          = 12;
    localparam int unsigned IDX_W           = 10;
    localparam int unsigned IDX_LSB         = 2;

    localparam logic [IDX_W-1:0] CTRL_IDX   = 10'h007;
    localparam logic [IDX_W-1:0] STATUS_IDX = 10'h01f;
    localparam logic [IDX_W-1:0] IO_LAST    = 10'h01f;
    localparam logic [IDX_W-1:0] CAN_FIRST  = 10'h020;
    localparam logic [IDX_W-1:0] CAN_LAST   = 10'h03d;
    localparam logic [IDX_W-1:0] ARR_FIRST  = 10'h100;
    localparam logic [IDX_W-1:0] ARR_LAST   = 10'h1ff;
    localparam logic [IDX_W-1:0] UPPER_LO   = 10'h120;

    localparam int unsigned ARR_DEPTH       = 256;
    localparam int unsigned ARR_AW          = 8;
    localparam logic [7:0]  OPTION_ADDR     = 8'h00;
    localparam int unsigned OPT_PROTECT_BIT = 1;

    // Control register fields.
    localparam int unsigned IRQ_EN_BIT      = 7;
    localparam int unsigned ASLEEP_BIT      = 6;
    localparam int unsigned CLKOPT_BIT      = 3;
    localparam int unsigned ERASE_BIT       = 2;
    localparam int unsigned LATCH_BIT       = 1;
    localparam int unsigned PUMP_BIT        = 0;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // Status register fields.
    localparam int unsigned ST_LATCHED_BIT  = 0;
    localparam int unsigned ST_PROTECT_BIT  = 1;
    localparam int unsigned ST_PUMP_BIT     = 2;
    localparam int unsigned ST_ERASE_BIT    = 3;

    localparam logic [7:0]  ERASED_BYTE     = 8'hff;
    localparam logic [7:0]  LATCHED_READ    = 8'hff;
    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;

    typedef enum logic [2:0] {
        ST_READ,
        ST_LOAD_PROG,
        ST_PROGRAMMING,
        ST_LOAD_ERASE,
        ST_ERASING
    } array_mode_e;

endpackage : eeprom_ctrl_pkg

//--- tb/cpu_bus_model.sv
`timescale 1ns/10ps

module cpu_bus_model
#(
    parameter int unsigned WAIT_CYC = 8
)
(
    input  wire logic        pclk,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata,
    output logic      [3:0]  pstrb
);
    localparam logic [11:0] CTRL_ADDR = 12'h01c;

    initial
    begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h00000000;
        pstrb   = 4'h1;
    end

    function automatic logic [11:0] arr(input logic [7:0] k);
        return {2'b01, k, 2'b00};
    endfunction : arr

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // A released bus must not keep showing the last address and data.
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask : xfer

    // no array reads while latched, timed wait
    task automatic byte_op(input logic [7:0] k, input logic [7:0] d, input logic era);
        logic [31:0] rd;
        logic        err;
        xfer(1'b1, CTRL_ADDR, {29'h0, era, 2'b10}, rd, err);
        xfer(1'b1, arr(k), {24'h0, d}, rd, err);
        xfer(1'b1, CTRL_ADDR, {29'h0, era, 2'b11}, rd, err);
        repeat (WAIT_CYC) @(posedge pclk);
        xfer(1'b1, CTRL_ADDR, 32'h00000000, rd, err);
    endtask : byte_op
endmodule : cpu_bus_model

//--- tb/eeprom_byte_prog_erase_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module eeprom_byte_prog_erase_ctrl_tb;
    localparam logic [11:0] CTRL = 12'h01c;
    logic        pclk, presetn, woi_mask_option, can_sleep_enter, can_wake, stop_entry;
    wire logic   psel, penable, pwrite, pready, pslverr;
    wire logic   wired_or_irq_enable, can_asleep_flag, bus_clock_out_option;
    wire logic   pump_voltage_pin, array_latched;
    wire logic [11:0] paddr;
    wire logic [31:0] pwdata, prdata;
    wire logic [3:0]  pstrb;
    int          fails = 0;
    int          cmp_count = 0;

    eeprom_byte_prog_erase_ctrl u_eeprom_byte_prog_erase_ctrl
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
        .pready, .pslverr, .woi_mask_option, .can_sleep_enter, .can_wake, .stop_entry,
        .wired_or_irq_enable, .can_asleep_flag, .bus_clock_out_option,
        .pump_voltage_pin, .array_latched
    );

    cpu_bus_model #(.WAIT_CYC(8)) u_cpu_bus_model
    (
        .pclk, .prdata, .pready, .pslverr, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb
    );

    function automatic logic [11:0] ad(input logic [7:0] k);
        return {2'b01, k, 2'b00};
    endfunction : ad

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic        err;
        u_cpu_bus_model.xfer(1'b1, a, {24'h000000, d}, rd, err);
    endtask : wr

    // Data is only compared where no refusal is expected.
    task automatic chk_rd(input logic [11:0] a, input logic [7:0] e, input logic ee);
        logic [31:0] rd;
        logic        err;
        u_cpu_bus_model.xfer(1'b0, a, 32'h00000000, rd, err);
        `CHK(err, ee)
        if (!ee)
            `CHK(rd, {24'h000000, e})
    endtask : chk_rd

    task automatic do_reset();
        presetn <= 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
    endtask : do_reset

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : final_report

    initial
    begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    initial
    begin
        repeat (5000) @(posedge pclk);
        fails++;
        final_report();
    end

    initial
    begin
        presetn = 1'b0;
        woi_mask_option = 1'b0;
        can_sleep_enter = 1'b0;
        can_wake = 1'b0;
        stop_entry = 1'b0;
        do_reset();
        chk_rd(CTRL, 8'h00, 1'b0);
        chk_rd(12'h080, 8'h00, 1'b1);
        wr(CTRL, 8'hff);
        chk_rd(CTRL, 8'h0e, 1'b0);
        chk_rd(ad(8'h05), 8'hff, 1'b0);
        wr(CTRL, 8'h0d);
        chk_rd(CTRL, 8'h08, 1'b0);
        `CHK(bus_clock_out_option, 1'b1)
        woi_mask_option <= 1'b1;
        wr(CTRL, 8'h80);
        @(posedge pclk);
        `CHK(wired_or_irq_enable, 1'b1)
        wr(CTRL, 8'h00);
        woi_mask_option <= 1'b0;
        @(posedge pclk) can_sleep_enter <= 1'b1;
        @(posedge pclk) can_sleep_enter <= 1'b0;
        chk_rd(CTRL, 8'h40, 1'b0);
        `CHK(can_asleep_flag, 1'b1)
        @(posedge pclk) can_wake <= 1'b1;
        @(posedge pclk) can_wake <= 1'b0;
        chk_rd(CTRL, 8'h00, 1'b0);
        wr(CTRL, 8'h06);
        wr(ad(8'h00), 8'h12);
        wr(CTRL, 8'h03);
        chk_rd(CTRL, 8'h07, 1'b0);
        `CHK(pump_voltage_pin, 1'b1)
        chk_rd(ad(8'h00), 8'h00, 1'b1);
        wr(CTRL, 8'h02);
        chk_rd(CTRL, 8'h07, 1'b0);
        wr(CTRL, 8'h00);
        @(posedge pclk);
        `CHK(pump_voltage_pin, 1'b0)
        chk_rd(ad(8'h00), 8'hff, 1'b0);
        u_cpu_bus_model.byte_op(8'h01, 8'h00, 1'b1);
        u_cpu_bus_model.byte_op(8'h02, 8'h00, 1'b1);
        wr(CTRL, 8'h02);
        wr(ad(8'h01), 8'h3c);
        wr(ad(8'h02), 8'h00);
        wr(CTRL, 8'h03);
        wr(CTRL, 8'h00);
        chk_rd(ad(8'h01), 8'h3c, 1'b0);
        chk_rd(ad(8'h02), 8'hff, 1'b0);
        u_cpu_bus_model.byte_op(8'h03, 8'h00, 1'b1);
        wr(CTRL, 8'h02);
        wr(ad(8'h03), 8'h00);
        wr(CTRL, 8'h03);
        stop_entry <= 1'b1;
        @(posedge pclk) stop_entry <= 1'b0;
        @(posedge pclk);
        `CHK(array_latched, 1'b0)
        chk_rd(ad(8'h03), 8'hff, 1'b0);
        do_reset();
        chk_rd(12'h07c, 8'h02, 1'b0);
        u_cpu_bus_model.byte_op(8'h40, 8'h00, 1'b1);
        u_cpu_bus_model.byte_op(8'h40, 8'h5a, 1'b0);
        chk_rd(ad(8'h40), 8'h5a, 1'b0);
        u_cpu_bus_model.byte_op(8'h00, 8'h00, 1'b0);
        do_reset();
        wr(CTRL, 8'h02);
        wr(ad(8'h41), 8'h00);
        wr(CTRL, 8'h03);
        chk_rd(CTRL, 8'h02, 1'b0);
        chk_rd(12'h07c, 8'h00, 1'b0);
        wr(CTRL, 8'h00);
        final_report();
    end
endmodule : eeprom_byte_prog_erase_ctrl_tb

//--- tb/eeprom_ctrl_properties.sv
`timescale 1ns/10ps

module eeprom_ctrl_properties
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        woi_mask_option,
    input wire logic        can_sleep_enter,
    input wire logic        can_wake,
    input wire logic        stop_entry,
    input wire logic        wired_or_irq_enable,
    input wire logic        can_asleep_flag,
    input wire logic        pump_voltage_pin,
    input wire logic        array_latched
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Data and refusal are fixed at the setup edge and shown in the access phase.
    sequence arr_setup;
        psel && !penable && paddr[11:10] == 2'b01;
    endsequence
    sequence access_phase;
        psel && penable;
    endsequence

    a_pump_needs_latch: assert property (pump_voltage_pin |-> array_latched)
        else $error("pump on without latch");
    a_erase_refuses: assert property (arr_setup ##0 pump_voltage_pin ##1 access_phase
        |-> pslverr) else $error("array access not refused while pump on");
    a_latched_reads_ff: assert property (arr_setup ##0 (!pwrite && array_latched
        && !pump_voltage_pin) ##1 access_phase |-> prdata == 32'h000000ff)
        else $error("latched array read not all ones");
    a_can_area_refused: assert property (psel && !penable && paddr[11:2] == 10'h020
        ##1 access_phase |-> pslverr) else $error("unmapped access not refused");
    a_ctrl_zero_bits: assert property (access_phase ##0 (!pwrite && paddr[11:2] == 10'h007)
        |-> prdata[31:8] == 24'h000000 && prdata[5:4] == 2'b00)
        else $error("control read has nonzero fixed bits");
    a_irq_en_forced: assert property (access_phase ##0 (pwrite && pstrb[0]
        && paddr[11:2] == 10'h007 && !woi_mask_option) |=> !wired_or_irq_enable)
        else $error("wired-or enable set without mask option");
    a_sleep_sets_flag: assert property (can_sleep_enter |=> can_asleep_flag)
        else $error("asleep flag not set");
    a_wake_clears_flag: assert property (can_wake && !can_sleep_enter |=> !can_asleep_flag)
        else $error("asleep flag not cleared");
    a_stop_clears_latch: assert property (stop_entry |=> !array_latched && !pump_voltage_pin)
        else $error("stop did not clear latch");
    a_pump_clear_via_latch: assert property ($fell(pump_voltage_pin) |-> !array_latched)
        else $error("pump cleared while latch held");
endmodule : eeprom_ctrl_properties

bind eeprom_byte_prog_erase_ctrl eeprom_ctrl_properties u_eeprom_ctrl_properties
(
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .prdata, .pslverr,
    .woi_mask_option, .can_sleep_enter, .can_wake, .stop_entry, .wired_or_irq_enable,
    .can_asleep_flag, .pump_voltage_pin, .array_latched
);
